// ===== design/bl_cfg.svh
/*
 Constants of the backlight enable and PWM front end: defaults,
 field encodings and timing figures. Assumes a 100 MHz system clock and a
 PWM sample clock that runs at the rate that the sample rate field selects.
*/
`ifndef BL_CFG_SVH
`define BL_CFG_SVH
// ============================================================
// Summary of operation
// R1: Enable pin low: disabled, settings at defaults, writes ignored, shutdown.
// R2: Enable pin high: device enabled and setting writes accepted.
// R3: Each of two strings has its own enable; both on after reset.
// R4: Host sets chip enable, then drives PWM high or writes nonzero code.
// R5: Reset defaults: chip enable on, PWM enabled, linear mapping.
// R6: Default settings: standby, watch PWM, duty becomes linear 11-bit code.
// R7: Current code comes from written code, PWM duty, or their product.
// R8: Pulse filter field rejects glitches: none, 100, 150 or 200 ns.
// R9: PWM quiet for the timeout period: PWM standby; period set by rate.
// R10: Duty resolved to full 11 bits at fastest rate, 1.6 to 12 kHz.
// R11: PWM high: backlight on within 5 ms after enable pin rises.
// R12: No string enabled or zero code: standby, LED current off.
// R13: Mode 00 written code, 01 PWM only, 10 or 11 the product.
// R14: Mapping bit picks exponential or linear; code 0 means no current.
// R15: Enable pin and PWM input are synchronised before use.

// ============================================================
// Clock and timing figures
`define CLK_MHZ 100
`define STARTUP_US 3500
`define KHZ_800K 800
`define KHZ_4M 4000
`define KHZ_24M 24000
`define IDLE_800K_US 25000
`define IDLE_4M_US 3000
`define IDLE_24M_US 600
`define GLITCH_100_NS 100
`define GLITCH_150_NS 150
`define GLITCH_200_NS 200
`define NS_PER_MS_KHZ 1000000
`define US_PER_MS 1000

// ============================================================
// Field encodings
`define CODE_W 11
`define CODE_MAX 11'h7FF
`define CODE_ZERO 11'h000
`define MODE_I2C 2'h0
`define MODE_PWM 2'h1
`define FILTER_OFF 2'h0
`define FILTER_100 2'h1
`define FILTER_150 2'h2
`define FILTER_200 2'h3
`define RATE_800K 2'h0
`define RATE_4M 2'h1

// ============================================================
// Reset values of the settings
`define DEF_CHIP_EN 1'h1
`define DEF_STRINGS 2'h3
`define DEF_PWM_EN 1'h1
`define DEF_MODE 2'h1
`define DEF_EXP 1'h0
`define DEF_FILTER 2'h1
`define DEF_RATE 2'h3
`define STRINGS_OFF 2'h0
`endif

// ===== design/bl_front_end.sv
/*
 Enable and PWM input front end of a two-string backlight driver: enable
 pin handling, settings with defaults, start-up delay, PWM filter, duty
 measurement, idle timeout and selection of the 11-bit current code.
 Assumes the two-wire slave presents decoded setting writes on cfg_*, and
 that sample_clock runs at the rate chosen by cfg_sample_rate.
*/
`timescale 1ns/100ps
`include "bl_cfg.svh"
module bl_front_end import bl_pkg::*; #(
	parameter int CNT_W = 16,
	parameter int STARTUP_CYCLES = `STARTUP_US * `CLK_MHZ,
	parameter int IDLE_24M_CYC = `IDLE_24M_US * `KHZ_24M / `US_PER_MS,
	parameter int IDLE_4M_CYC = `IDLE_4M_US * `KHZ_4M / `US_PER_MS,
	parameter int IDLE_800K_CYC = `IDLE_800K_US * `KHZ_800K / `US_PER_MS
) (
	// System clock and reset
	input wire logic clock,
	input wire logic nrst,
	// PWM sample clock
	input wire logic sample_clock,
	// Pins
	input wire logic hardware_enable_pin,
	input wire logic pwm_pin,
	// Setting writes
	input wire logic cfg_write,
	input wire logic cfg_chip_enable,
	input wire logic [1:0] cfg_string_enable,
	input wire logic cfg_pwm_enable,
	input wire logic [1:0] cfg_brightness_mode,
	input wire logic cfg_exp_mapping,
	input wire logic [1:0] cfg_pulse_filter,
	input wire logic [1:0] cfg_sample_rate,
	input wire logic [10:0] cfg_brightness_code,
	// Status
	output logic cfg_accept,
	output logic shutdown,
	output logic standby,
	output logic backlight_on,
	output logic pwm_idle,
	output logic [10:0] pwm_duty_code,
	// Current sink drive
	output logic [10:0] led_code,
	output logic [1:0] string_drive,
	output logic exp_mapping
);
	localparam int CW = `CODE_W;
	localparam int SW = $clog2(STARTUP_CYCLES + 1);
	localparam int G1 = `GLITCH_100_NS * `KHZ_24M / `NS_PER_MS_KHZ;
	localparam int G2 = `GLITCH_150_NS * `KHZ_24M / `NS_PER_MS_KHZ;
	localparam int G3 = `GLITCH_200_NS * `KHZ_24M / `NS_PER_MS_KHZ;
	localparam int DIV_LAST = CW - 1;

	if (CNT_W < 8 || 2 ** CNT_W <= IDLE_800K_CYC || 2 ** CNT_W <= IDLE_4M_CYC ||
		2 ** CNT_W <= IDLE_24M_CYC || IDLE_24M_CYC < 16 || STARTUP_CYCLES < 2) begin : g_bad
		$error("bl_front_end: counter width or timing out of range");
	end

	// ============================================================
	// Enable pin and settings (system clock)
	logic [2:0] hardware_enable_pin_sync_r;
	logic hardware_enable_pin_lvl_r;
	logic regs_clear;
	logic chip_en_r;
	logic [1:0] strings_r;
	logic pwm_en_r;
	logic [1:0] mode_r;
	logic exp_r;
	logic [1:0] filter_r;
	logic [1:0] rate_r;
	logic [CW-1:0] i2c_code_r;

	// R15 enable pin settles before use
	always_ff @(posedge clock) begin
		hardware_enable_pin_sync_r <= {hardware_enable_pin_sync_r[1:0], hardware_enable_pin};
		if (!nrst)
			hardware_enable_pin_lvl_r <= 1'h0;
		else if (hardware_enable_pin_sync_r[1] == hardware_enable_pin_sync_r[2])
			hardware_enable_pin_lvl_r <= hardware_enable_pin_sync_r[2];
	end

	// R1 low pin holds everything in reset
	assign regs_clear = !nrst || !hardware_enable_pin_lvl_r;
	// R2 writes only while enabled
	assign cfg_accept = cfg_write && !regs_clear;

	// R5 defaults, R3 both strings on
	always_ff @(posedge clock) begin
		if (regs_clear) begin
			chip_en_r <= `DEF_CHIP_EN;
			strings_r <= `DEF_STRINGS;
			pwm_en_r <= `DEF_PWM_EN;
			mode_r <= `DEF_MODE;
			exp_r <= `DEF_EXP;
			filter_r <= `DEF_FILTER;
			rate_r <= `DEF_RATE;
			i2c_code_r <= `CODE_ZERO;
		end else if (cfg_write) begin
			chip_en_r <= cfg_chip_enable;
			strings_r <= cfg_string_enable;
			pwm_en_r <= cfg_pwm_enable;
			mode_r <= cfg_brightness_mode;
			exp_r <= cfg_exp_mapping;
			filter_r <= cfg_pulse_filter;
			rate_r <= cfg_sample_rate;
			i2c_code_r <= cfg_brightness_code;
		end
	end

	// ============================================================
	// Settings into the sample domain
	bl_state_t state_r;
	bl_state_t state_nxt;
	logic [5:0] cfg_bus;
	logic [5:0] cfg_sync_r [3];
	logic [5:0] s_cfg_r;
	logic s_run;
	logic [1:0] s_filter;
	logic [1:0] s_rate;

	// Quasi-static bundle: taken only when two stages agree
	assign cfg_bus = {pwm_en_r, filter_r, rate_r, state_r != ST_SHUTDOWN};
	always_ff @(posedge sample_clock) begin
		cfg_sync_r[0] <= cfg_bus;
		cfg_sync_r[1] <= cfg_sync_r[0];
		cfg_sync_r[2] <= cfg_sync_r[1];
		if (cfg_sync_r[1] == cfg_sync_r[2])
			s_cfg_r <= cfg_sync_r[2];
	end
	assign s_run = s_cfg_r[0];
	assign s_rate = s_cfg_r[2:1];
	assign s_filter = s_cfg_r[4:3];

	// ============================================================
	// PWM sampling and duty measurement (sample clock)
	logic [2:0] pwm_sync_r;
	logic pwm_lvl_r;
	logic clean;
	logic clean_d_r;
	logic rise;
	logic edge_seen;
	meas_state_t meas_r;
	logic [CNT_W-1:0] hi_cnt_r;
	logic [CNT_W-1:0] per_cnt_r;
	logic [CNT_W-1:0] idle_cnt_r;
	logic [CNT_W-1:0] idle_lim;
	logic idle_fire;
	logic div_go;
	logic div_done;
	logic [3:0] div_cnt_r;
	logic [CNT_W:0] rem_r;
	logic [CNT_W:0] rem_sh;
	logic [CNT_W:0] den_r;
	logic div_ge;
	logic [CW-1:0] quo_r;
	logic [CW-1:0] quo_nxt;
	logic [CW-1:0] code_s_r;
	logic idle_s_r;
	logic tgl_s_r;

	// R15 PWM pin settles before filtering
	always_ff @(posedge sample_clock) begin
		pwm_sync_r <= {pwm_sync_r[1:0], pwm_pin};
		if (!s_run)
			pwm_lvl_r <= 1'h0;
		else if (pwm_sync_r[1] == pwm_sync_r[2])
			pwm_lvl_r <= pwm_sync_r[2];
	end

	pwm_glitch_filter #(
		.CNT_W(4),
		.LIM1(G1 < 1 ? 1 : G1),
		.LIM2(G2 < 1 ? 1 : G2),
		.LIM3(G3 < 1 ? 1 : G3)
	) u_filter (
		.sample_clock(sample_clock),
		.run(s_run),
		.raw_level(pwm_lvl_r),
		.filter_sel(s_filter),
		.clean_level(clean)
	);

	// R9 timeout follows the sample rate
	assign idle_lim = (s_rate == `RATE_800K) ? CNT_W'(IDLE_800K_CYC) :
		(s_rate == `RATE_4M) ? CNT_W'(IDLE_4M_CYC) : CNT_W'(IDLE_24M_CYC);
	assign rise = clean && !clean_d_r;
	assign edge_seen = clean != clean_d_r;
	assign idle_fire = (idle_cnt_r == idle_lim - CNT_W'(1)) && meas_r != MS_DIV;
	assign div_go = rise && meas_r == MS_COUNT;
	assign div_done = meas_r == MS_DIV && div_cnt_r == 4'(DIV_LAST);

	// R10 one quotient bit per cycle, 11 in all
	assign rem_sh = {rem_r[CNT_W-1:0], 1'h0};
	assign div_ge = rem_sh >= den_r;
	assign quo_nxt = {quo_r[CW-2:0], div_ge};

	// Period, high time and quiet time counters
	always_ff @(posedge sample_clock) begin
		clean_d_r <= s_run && clean;
		if (!s_run || rise) begin
			hi_cnt_r <= CNT_W'(1);
			per_cnt_r <= CNT_W'(1);
		end else if (~&per_cnt_r) begin
			per_cnt_r <= per_cnt_r + CNT_W'(1);
			hi_cnt_r <= hi_cnt_r + CNT_W'(clean);
		end
		if (!s_run || edge_seen)
			idle_cnt_r <= {CNT_W{1'h0}};
		else if (idle_cnt_r < idle_lim)
			idle_cnt_r <= idle_cnt_r + CNT_W'(1);
	end

	// R6 duty to code; R9 quiet input posts standby
	always_ff @(posedge sample_clock) begin
		if (!s_run) begin
			meas_r <= MS_WAIT;
			div_cnt_r <= 4'h0;
			rem_r <= {(CNT_W + 1){1'h0}};
			den_r <= {(CNT_W + 1){1'h0}};
			quo_r <= `CODE_ZERO;
			code_s_r <= `CODE_ZERO;
			idle_s_r <= 1'h1;
			tgl_s_r <= 1'h0;
		end else begin
			unique case (meas_r)
				MS_WAIT: begin
					if (rise)
						meas_r <= MS_COUNT;
				end
				MS_COUNT: begin
					if (div_go) begin
						meas_r <= MS_DIV;
						rem_r <= {1'h0, hi_cnt_r};
						den_r <= {1'h0, per_cnt_r};
						div_cnt_r <= 4'h0;
					end
				end
				MS_DIV: begin
					rem_r <= div_ge ? rem_sh - den_r : rem_sh;
					quo_r <= quo_nxt;
					div_cnt_r <= div_cnt_r + 4'h1;
					if (div_done)
						meas_r <= MS_COUNT;
				end
			endcase
			if (div_done) begin
				code_s_r <= quo_nxt;
				idle_s_r <= 1'h0;
				tgl_s_r <= !tgl_s_r;
			end else if (idle_fire) begin
				code_s_r <= clean ? `CODE_MAX : `CODE_ZERO;
				idle_s_r <= 1'h1;
				tgl_s_r <= !tgl_s_r;
				meas_r <= MS_WAIT;
			end
		end
	end

	// ============================================================
	// Result back to the system clock
	logic [2:0] tgl_sync_r;
	logic tgl_seen_r;
	logic new_res;
	logic [CW-1:0] pwm_code_r;
	logic pwm_idle_r;

	// Data is held for a whole divide, far longer than the toggle sync
	assign new_res = tgl_sync_r[1] == tgl_sync_r[2] && tgl_sync_r[2] != tgl_seen_r;
	always_ff @(posedge clock) begin
		tgl_sync_r <= {tgl_sync_r[1:0], tgl_s_r};
		if (regs_clear) begin
			tgl_seen_r <= tgl_sync_r[2];
			pwm_code_r <= `CODE_ZERO;
			pwm_idle_r <= 1'h1;
		end else if (new_res) begin
			tgl_seen_r <= tgl_sync_r[2];
			pwm_code_r <= code_s_r;
			pwm_idle_r <= idle_s_r;
		end
	end

	// ============================================================
	// Code selection and state
	logic [CW-1:0] pwm_eff;
	logic [2*CW-1:0] prod;
	logic [CW-1:0] src_code;
	logic want_on;
	logic [SW-1:0] start_cnt_r;
	logic start_done;
	logic [CW-1:0] led_code_r;
	logic [1:0] drive_r;

	// R7 sources; R13 mode decode
	assign pwm_eff = pwm_en_r ? pwm_code_r : `CODE_ZERO;
	assign prod = i2c_code_r * pwm_eff;
	assign src_code = (mode_r == `MODE_I2C) ? i2c_code_r :
		(mode_r == `MODE_PWM) ? pwm_eff : prod[2*CW-1:CW];
	// R12 no strings or zero code keeps standby
	assign want_on = chip_en_r && strings_r != `STRINGS_OFF && src_code != `CODE_ZERO;
	assign start_done = start_cnt_r == SW'(STARTUP_CYCLES - 1);

	// R11 fixed start-up delay before current
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_SHUTDOWN: state_nxt = ST_POWERUP;
			ST_POWERUP: if (start_done) state_nxt = chip_en_r ? ST_STANDBY : ST_DISABLED;
			ST_DISABLED: if (chip_en_r) state_nxt = ST_STANDBY;
			ST_STANDBY: begin
				if (!chip_en_r) state_nxt = ST_DISABLED;
				else if (want_on) state_nxt = ST_ACTIVE;
			end
			ST_ACTIVE: begin
				if (!chip_en_r) state_nxt = ST_DISABLED;
				else if (!want_on) state_nxt = ST_STANDBY;
			end
			default: state_nxt = ST_SHUTDOWN;
		endcase
	end

	// R1 low pin forces shutdown
	always_ff @(posedge clock) begin
		if (regs_clear) begin
			state_r <= ST_SHUTDOWN;
			start_cnt_r <= {SW{1'h0}};
		end else begin
			state_r <= state_nxt;
			start_cnt_r <= (state_r == ST_POWERUP) ? start_cnt_r + SW'(1) : {SW{1'h0}};
		end
	end

	// R14 zero code gives no current
	always_ff @(posedge clock) begin
		if (regs_clear) begin
			led_code_r <= `CODE_ZERO;
			drive_r <= `STRINGS_OFF;
		end else begin
			led_code_r <= (state_r == ST_ACTIVE) ? src_code : `CODE_ZERO;
			drive_r <= (state_r == ST_ACTIVE) ? strings_r : `STRINGS_OFF;
		end
	end

	assign shutdown = state_r == ST_SHUTDOWN;
	assign standby = state_r == ST_STANDBY || state_r == ST_DISABLED;
	assign backlight_on = state_r == ST_ACTIVE;
	assign pwm_idle = pwm_idle_r;
	assign pwm_duty_code = pwm_code_r;
	assign led_code = led_code_r;
	assign string_drive = drive_r;
	// R14 mapping bit passed to the sinks
	assign exp_mapping = exp_r;

	// ============================================================
	// Checks
	a_shutdown_enter: assert property (@(posedge clock) disable iff (!nrst) // R1
		!hardware_enable_pin_lvl_r |=> state_r == ST_SHUTDOWN && led_code == `CODE_ZERO && string_drive == `STRINGS_OFF)
		else $error("device not shut down with enable pin low");
	a_write_ignored: assert property (@(posedge clock) disable iff (!nrst) // R1
		cfg_write && !hardware_enable_pin_lvl_r |=> mode_r == `DEF_MODE && i2c_code_r == `CODE_ZERO)
		else $error("setting write taken while disabled");
	a_write_taken: assert property (@(posedge clock) disable iff (!nrst) // R2
		cfg_accept |=> mode_r == $past(cfg_brightness_mode) && i2c_code_r == $past(cfg_brightness_code))
		else $error("setting write lost while enabled");
	a_strings_default: assert property (@(posedge clock) disable iff (!nrst) // R3
		$rose(hardware_enable_pin_lvl_r) |-> strings_r == `DEF_STRINGS)
		else $error("strings not both enabled after reset");
	a_reset_default: assert property (@(posedge clock) disable iff (!nrst) // R5
		state_r == ST_POWERUP && start_cnt_r == {SW{1'h0}} |-> chip_en_r && pwm_en_r && !exp_r)
		else $error("settings not at defaults after reset");
	a_startup_time: assert property (@(posedge clock) disable iff (!nrst) // R11
		start_done && state_r == ST_POWERUP && hardware_enable_pin_lvl_r |=> state_r != ST_POWERUP)
		else $error("start-up delay overran");
	a_standby_off: assert property (@(posedge clock) disable iff (!nrst) // R12
		state_r == ST_ACTIVE && !want_on |=> state_r != ST_ACTIVE
		##1 (led_code == `CODE_ZERO && string_drive == `STRINGS_OFF))
		else $error("current on with no string or zero code");
	a_mode_i2c: assert property (@(posedge clock) disable iff (!nrst) // R13
		state_r == ST_ACTIVE && mode_r == `MODE_I2C |=> led_code == $past(i2c_code_r))
		else $error("written-code mode drove another code");
	a_mode_pwm: assert property (@(posedge clock) disable iff (!nrst) // R7
		state_r == ST_ACTIVE && mode_r == `MODE_PWM ##1 state_r == ST_ACTIVE |-> led_code == $past(pwm_eff))
		else $error("PWM mode drove another code");
	a_div_length: assert property (@(posedge sample_clock) disable iff (!s_run) // R10
		div_go |-> ##12 $changed(tgl_s_r))
		else $error("duty divide did not finish in 11 steps");
	a_idle_post: assert property (@(posedge sample_clock) disable iff (!s_run) // R9
		idle_fire |=> idle_s_r && $changed(tgl_s_r))
		else $error("quiet input not posted as standby");

	c_active_pwm: cover property (@(posedge clock) disable iff (!nrst) state_r == ST_ACTIVE && mode_r == `MODE_PWM);
	c_active_prod: cover property (@(posedge clock) disable iff (!nrst) state_r == ST_ACTIVE && mode_r[1]);
	c_idle_seen: cover property (@(posedge sample_clock) disable iff (!s_run) idle_fire);
	c_startup_end: cover property (@(posedge clock) disable iff (!nrst) start_done && state_r == ST_POWERUP);
endmodule

// ===== design/bl_pkg.sv
/*
 Types shared by the backlight front end. Assumes bl_cfg.svh for figures.
*/
package bl_pkg;
	// Device operating state
	typedef enum logic [4:0] {
		ST_SHUTDOWN = 5'h01,
		ST_POWERUP = 5'h02,
		ST_DISABLED = 5'h04,
		ST_STANDBY = 5'h08,
		ST_ACTIVE = 5'h10
	} bl_state_t;
	// Duty measurement state in the sample domain
	typedef enum logic [2:0] {
		MS_WAIT = 3'h1,
		MS_COUNT = 3'h2,
		MS_DIV = 3'h4
	} meas_state_t;
endpackage

// ===== design/pwm_glitch_filter.sv
/*
 Glitch filter for the synchronised PWM level, in the sample clock domain.
 Assumes its input is already synchronised to sample_clock.
*/
`timescale 1ns/100ps
`include "bl_cfg.svh"
module pwm_glitch_filter import bl_pkg::*; #(
	parameter int CNT_W = 4,
	parameter int LIM1 = 2,
	parameter int LIM2 = 3,
	parameter int LIM3 = 4
) (
	// Sample clock and run level
	input wire logic sample_clock,
	input wire logic run,
	// Level and window choice
	input wire logic raw_level,
	input wire logic [1:0] filter_sel,
	// Clean level
	output logic clean_level
);
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic [CNT_W-1:0] limit;
	logic level_r;
	logic differ;
	logic flip;

	// ============================================================
	// Window decode
	if (LIM1 < 1 || LIM2 < LIM1 || LIM3 < LIM2 || LIM3 >= 2 ** CNT_W) begin : g_bad
		$error("pwm_glitch_filter: window limits do not fit");
	end

	// R8 window per setting
	assign limit = (filter_sel == `FILTER_OFF) ? CNT_W'(1) :
		(filter_sel == `FILTER_100) ? CNT_W'(LIM1) :
		(filter_sel == `FILTER_150) ? CNT_W'(LIM2) : CNT_W'(LIM3);
	assign differ = raw_level != level_r;
	assign cnt_nxt = differ ? cnt_r + CNT_W'(1) : {CNT_W{1'h0}};
	assign flip = differ && (cnt_nxt >= limit);
	assign clean_level = level_r;

	// R8 pulses shorter than window vanish
	always_ff @(posedge sample_clock) begin
		if (!run) begin
			cnt_r <= {CNT_W{1'h0}};
			level_r <= 1'h0;
		end else begin
			cnt_r <= flip ? {CNT_W{1'h0}} : cnt_nxt;
			level_r <= flip ? raw_level : level_r;
		end
	end

	// ============================================================
	// Checks
	a_filter_pass: assert property (@(posedge sample_clock) disable iff (!run) // R8
		differ && filter_sel == `FILTER_OFF |=> clean_level == $past(raw_level))
		else $error("unfiltered level did not follow input");
	a_filter_long: assert property (@(posedge sample_clock) disable iff (!run) // R8
		$rose(clean_level) && filter_sel == `FILTER_200 && $past(filter_sel, LIM3) == `FILTER_200
		|-> $past(raw_level, LIM3))
		else $error("short pulse passed the widest window");
endmodule

// ===== verif/pwm_host_model.sv
/*
 Host side of the PWM pin: a steady level or a pulse train.
 Assumes the device's sample clock as timebase and period_len >= 13.
*/
`timescale 1ns/100ps
module pwm_host_model (
	// Timebase
	input wire logic sample_clock,
	// Waveform choice
	input wire logic run,
	input wire logic idle_level,
	input wire logic [7:0] high_len,
	input wire logic [7:0] period_len,
	// Pin
	output logic pwm_pin
);
	// ============================================================
	// Pulse train
	logic [7:0] cnt_r = 8'h00;
	// Falling edge, so the device never samples a moving level
	always @(negedge sample_clock) begin
		if (!run || cnt_r >= period_len - 8'h01) begin
			cnt_r <= 8'h00;
		end else begin
			cnt_r <= cnt_r + 8'h01;
		end
	end
	assign pwm_pin = run ? (cnt_r < high_len) : idle_level;
endmodule

// ===== verif/tb_top.sv
/*
 Self-checking bench of the backlight front end with a PWM host model.
 Assumes shortened start-up and idle counts set below.
*/
`timescale 1ns/100ps
module tb_top;
	// ============================================================
	// Signals
	localparam int STARTUP = 200;
	logic clock = 1'b0;
	logic sample_clock = 1'b0;
	logic nrst = 1'b0;
	logic hardware_enable_pin = 1'b0;
	logic pwm_pin;
	logic cfg_write = 1'b0;
	logic cfg_chip_enable = 1'b1;
	logic [1:0] cfg_string_enable = 2'h3;
	logic cfg_pwm_enable = 1'b1;
	logic [1:0] cfg_brightness_mode = 2'h1;
	logic cfg_exp_mapping = 1'b0;
	logic [1:0] cfg_pulse_filter = 2'h1;
	logic [1:0] cfg_sample_rate = 2'h3;
	logic [10:0] cfg_brightness_code = 11'h000;
	logic cfg_accept, shutdown, standby, backlight_on, pwm_idle, exp_mapping;
	logic [10:0] pwm_duty_code, led_code;
	logic [1:0] string_drive;
	logic pwm_run = 1'b0;
	logic pwm_level = 1'b1;
	logic [7:0] high_len = 8'h04;
	logic [7:0] period_len = 8'h10;
	int n_mismatch = 0;
	int check_count = 0;

	// Clocks; sample clock offset so its edges never meet a system clock edge
	always #5 clock = ~clock;
	initial begin
		#13;
		forever #40 sample_clock = ~sample_clock;
	end

	bl_front_end #(.STARTUP_CYCLES(STARTUP), .IDLE_24M_CYC(40), .IDLE_4M_CYC(60), .IDLE_800K_CYC(80))
		bl_front_end_inst (.clock(clock), .nrst(nrst), .sample_clock(sample_clock),
		.hardware_enable_pin(hardware_enable_pin), .pwm_pin(pwm_pin), .cfg_write(cfg_write),
		.cfg_chip_enable(cfg_chip_enable), .cfg_string_enable(cfg_string_enable),
		.cfg_pwm_enable(cfg_pwm_enable), .cfg_brightness_mode(cfg_brightness_mode),
		.cfg_exp_mapping(cfg_exp_mapping), .cfg_pulse_filter(cfg_pulse_filter),
		.cfg_sample_rate(cfg_sample_rate), .cfg_brightness_code(cfg_brightness_code),
		.cfg_accept(cfg_accept), .shutdown(shutdown), .standby(standby), .backlight_on(backlight_on),
		.pwm_idle(pwm_idle), .pwm_duty_code(pwm_duty_code), .led_code(led_code),
		.string_drive(string_drive), .exp_mapping(exp_mapping));

	pwm_host_model pwm_host_model_inst (.sample_clock(sample_clock), .run(pwm_run),
		.idle_level(pwm_level), .high_len(high_len), .period_len(period_len), .pwm_pin(pwm_pin));

	// ============================================================
	// Compare and drive tasks
	task automatic cmp1(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp2(input logic [1:0] got, input logic [1:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp11(input logic [10:0] got, input logic [10:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic clks(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	// One-cycle setting write; acceptance is judged in the same cycle
	task automatic wr(input logic [1:0] m, input logic [10:0] c, input logic [1:0] s, input logic ce,
		input logic ex, input logic [1:0] f, input logic [1:0] r, input logic acc);
		@(posedge clock);
		cfg_write <= 1'b1;
		cfg_brightness_mode <= m;
		cfg_brightness_code <= c;
		cfg_string_enable <= s;
		cfg_chip_enable <= ce;
		cfg_exp_mapping <= ex;
		cfg_pulse_filter <= f;
		cfg_sample_rate <= r;
		#1;
		cmp1(cfg_accept, acc);
		@(posedge clock);
		cfg_write <= 1'b0;
	endtask
	task automatic pwm(input logic run, input logic lvl, input logic [7:0] h);
		@(posedge clock);
		pwm_run <= run;
		pwm_level <= lvl;
		high_len <= h;
	endtask

	// ============================================================
	// Scenarios
	task automatic t_reset;
		clks(5);
		wr(2'h0, 11'h123, 2'h1, 1'b1, 1'b1, 2'h0, 2'h0, 1'b0);
		cmp1(shutdown, 1'b1);
		cmp1(pwm_idle, 1'b1);
		cmp11(led_code, 11'h000);
		cmp1(exp_mapping, 1'b0);
		repeat (5) @(posedge clock);
		nrst <= 1'b1;
		clks(10);
		cmp1(shutdown, 1'b1);
	endtask
	// Pin rises with PWM steady high; current must follow after the start-up delay
	task automatic t_startup;
		int n;
		n = 0;
		pwm(1'b0, 1'b1, 8'h04);
		@(posedge clock);
		hardware_enable_pin <= 1'b1;
		while (backlight_on !== 1'b1 && n < 1000) begin
			clks(1);
			n++;
		end
		cmp1(n >= STARTUP && n <= STARTUP + 440, 1'b1);
		clks(3);
		cmp11(led_code, 11'h7FF);
		cmp2(string_drive, 2'h3);
		cmp1(exp_mapping, 1'b0);
	endtask
	task automatic t_duty;
		logic [7:0] hs[3] = '{8'h04, 8'h0C, 8'h0E};
		logic [10:0] es[3] = '{11'h200, 11'h600, 11'h700};
		for (int i = 0; i < 3; i++) begin
			pwm(1'b1, 1'b0, hs[i]);
			clks(480);
			cmp11(pwm_duty_code, es[i]);
			cmp11(led_code, es[i]);
			cmp1(pwm_idle, 1'b0);
		end
	endtask
	// Every filter code: off and 150 ns with a longer pulse, 100 ns with a shorter one, 200 ns with both
	task automatic t_glitch;
		logic [1:0] fs[5] = '{2'h1, 2'h0, 2'h3, 2'h3, 2'h2};
		logic [7:0] hs[5] = '{8'h01, 8'h02, 8'h03, 8'h06, 8'h04};
		logic [10:0] es[5] = '{11'h000, 11'h100, 11'h000, 11'h300, 11'h200};
		for (int i = 0; i < 5; i++) begin
			wr(2'h1, 11'h000, 2'h3, 1'b1, 1'b0, fs[i], 2'h3, 1'b1);
			pwm(1'b1, 1'b0, hs[i]);
			clks(800);
			cmp11(pwm_duty_code, es[i]);
			cmp11(led_code, es[i]);
			cmp1(standby, es[i] == 11'h000);
		end
	endtask
	task automatic mode_case(input logic [1:0] m, input logic [10:0] c, input logic [1:0] s, input logic ce,
		input logic ex, input logic [10:0] el, input logic [1:0] es, input logic eb);
		wr(m, c, s, ce, ex, 2'h1, 2'h3, 1'b1);
		clks(STARTUP + 20);
		cmp11(led_code, el);
		cmp2(string_drive, es);
		cmp1(backlight_on, eb);
		cmp1(exp_mapping, ex);
	endtask
	task automatic t_mode;
		pwm(1'b1, 1'b0, 8'h08);
		clks(480);
		mode_case(2'h0, 11'h123, 2'h3, 1'b1, 1'b0, 11'h123, 2'h3, 1'b1);
		mode_case(2'h2, 11'h400, 2'h3, 1'b1, 1'b0, 11'h200, 2'h3, 1'b1);
		mode_case(2'h3, 11'h7FF, 2'h1, 1'b1, 1'b1, 11'h3FF, 2'h1, 1'b1);
		mode_case(2'h0, 11'h000, 2'h3, 1'b1, 1'b0, 11'h000, 2'h0, 1'b0);
		mode_case(2'h0, 11'h123, 2'h0, 1'b1, 1'b0, 11'h000, 2'h0, 1'b0);
		mode_case(2'h0, 11'h123, 2'h2, 1'b0, 1'b0, 11'h000, 2'h0, 1'b0);
		mode_case(2'h1, 11'h000, 2'h2, 1'b1, 1'b1, 11'h400, 2'h2, 1'b1);
		// PWM source switched off: the PWM-only mode must fall back to standby
		@(posedge clock);
		cfg_pwm_enable <= 1'b0;
		mode_case(2'h1, 11'h000, 2'h2, 1'b1, 1'b0, 11'h000, 2'h0, 1'b0);
		@(posedge clock);
		cfg_pwm_enable <= 1'b1;
	endtask
	// Timeout per sample rate, judged shortly before and after it expires
	task automatic t_idle;
		logic [1:0] rs[3] = '{2'h1, 2'h0, 2'h2};
		int cs[3] = '{60, 80, 40};
		logic [10:0] es[3] = '{11'h000, 11'h7FF, 11'h000};
		for (int i = 0; i < 3; i++) begin
			wr(2'h1, 11'h000, 2'h3, 1'b1, 1'b0, 2'h1, rs[i], 1'b1);
			pwm(1'b1, 1'b0, 8'h08);
			clks(480);
			pwm(1'b0, es[i][0], 8'h08);
			clks((cs[i] - 10) * 8);
			cmp1(pwm_idle, 1'b0);
			clks(30 * 8);
			cmp1(pwm_idle, 1'b1);
			cmp11(pwm_duty_code, es[i]);
		end
	endtask
	task automatic t_pin_low;
		@(posedge clock);
		hardware_enable_pin <= 1'b0;
		clks(8);
		cmp1(shutdown, 1'b1);
		cmp1(exp_mapping, 1'b0);
		cmp11(led_code, 11'h000);
		wr(2'h0, 11'h123, 2'h1, 1'b1, 1'b1, 2'h1, 2'h3, 1'b0);
		@(posedge clock);
		hardware_enable_pin <= 1'b1;
		clks(8);
		cmp1(shutdown, 1'b0);
		wr(2'h0, 11'h123, 2'h1, 1'b1, 1'b1, 2'h1, 2'h3, 1'b1);
	endtask

	// ============================================================
	// Verdict, watchdog and main sequence
	task automatic final_report;
		$display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Run needs about 12000 clocks; the limit leaves ample slack
	initial begin
		repeat (40000) @(posedge clock);
		n_mismatch++;
		final_report();
	end
	initial begin
		t_reset();
		t_startup();
		t_duty();
		t_glitch();
		t_mode();
		t_idle();
		t_pin_low();
		final_report();
	end
endmodule
